// ---- hdl/rlt_defines.svh ----
// Register offsets, field positions, reset values and codes of the reload timer
`ifndef RLT_DEFINES_SVH
`define RLT_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define RLT_ADDR_W           3
`define RLT_OFS_CTRL_UPPER   3'h0
`define RLT_OFS_CTRL_LOWER   3'h1
`define RLT_OFS_CNT_UPPER    3'h2
`define RLT_OFS_CNT_LOWER    3'h3
`define RLT_OFS_RLD_UPPER    3'h4
`define RLT_OFS_RLD_LOWER    3'h5
`define RLT_OFS_INT_STAT     3'h6
`define RLT_OFS_INT_MASK     3'h7

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RLT_CU_CSL_LSB       0
`define RLT_CU_MOD_LSB       3
`define RLT_CL_OUTPUT_ENABLE_BIT          7
`define RLT_CL_OUTL          6
`define RLT_CL_RELOAD_SELECT_BIT          5
`define RLT_CL_UNDERFLOW_IRQ_ENABLE          4
`define RLT_CL_UF            3
`define RLT_CL_COUNT_ENABLE_BIT          2
`define RLT_CL_TRG           1
`define RLT_CL_RUN           0
`define RLT_IS_UF            0

// ----------------------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------------------
`define RLT_CSL_EVENT        3'h7
`define RLT_CNT_UNDER        16'hFFFF
`define RLT_CNT_ZERO         16'h0000
`define RLT_RST_CNT          16'h0000
`define RLT_RST_RELOAD       16'h0000
`define RLT_RST_CSL          3'h0
`define RLT_RST_MOD          3'h0

`endif

// ---- hdl/rlt_pkg.sv ----
// Types shared by the reload timer modules
`default_nettype none

package rlt_pkg;

  // Counter operating state
  typedef enum logic [1:0] {
    st_stop,
    st_wait,
    st_run
  } rlt_run_e;

  // Register bus request from the master
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rlt_bus_s;

  // Whole state of the timer channel except the prescaler divider
  typedef struct packed {
    logic       tin_meta;
    logic       tin_sync;
    logic       tin_prev;
    rlt_run_e   st;
    logic [15:0] cnt;
    logic [15:0] reload;
    logic [2:0] count_clock_select;
    logic [2:0] operating_mode_select;
    logic       output_enable_bit;
    logic       out_level_inv;
    logic       reload_select_bit;
    logic       underflow_irq_enable;
    logic       underflow_flag;
    logic       count_enable_bit;
    logic       tout_level;
    logic       pin_level;
    logic       irq;
    logic [7:0] rdata;
  } rlt_regs_s;

endpackage

`default_nettype wire

// ---- hdl/rlt_prescaler.sv ----
// Free-running prescaler giving a one-cycle count tick
`timescale 1ns/1ns
`default_nettype none

module rlt_prescaler #(
  parameter int DIV_W = 7
) (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic [2:0] sel,
  output logic            tick
);

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic             tick;
  } rlt_psc_s;

  rlt_psc_s         r;
  rlt_psc_s         next_r;
  logic [DIV_W-1:0] mask;

  // ----------------------------------------------------------------------------
  // Divide by 2^(sel+1); tick fires once per period
  // ----------------------------------------------------------------------------
  always_comb begin
    next_r      = r;
    mask        = DIV_W'((8'h02 << sel) - 8'h01);
    next_r.div  = r.div + 1'b1;
    next_r.tick = (r.div & mask) == mask;
  end

  // Registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tick = r.tick;

endmodule

`default_nettype wire

// ---- hdl/rlt_timer.sv ----
// One channel of the 16-bit reload down-counter timer with register port
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "rlt_defines.svh"

module rlt_timer
  import rlt_pkg::*;
#(
  parameter int PSC_W = 7
) (
  input  wire logic     clk_sys,
  input  wire logic     nrst,
  input  wire rlt_bus_s bus,
  output logic [7:0]    rdata,
  input  wire logic     timer_input_pin,
  output logic          timer_output_pin,
  output logic          timer_output_en,
  output logic          irq
);

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  localparam rlt_regs_s RST = '{
    tin_meta:              1'b0,
    tin_sync:              1'b0,
    tin_prev:              1'b0,
    st:                    st_stop,
    cnt:                   `RLT_RST_CNT,
    reload:                `RLT_RST_RELOAD,
    count_clock_select:    `RLT_RST_CSL,
    operating_mode_select: `RLT_RST_MOD,
    output_enable_bit:     1'b0,
    out_level_inv:         1'b0,
    reload_select_bit:     1'b0,
    underflow_irq_enable:  1'b0,
    underflow_flag:        1'b0,
    count_enable_bit:      1'b0,
    tout_level:            1'b0,
    pin_level:             1'b0,
    irq:                   1'b0,
    rdata:                 8'h00
  };

  rlt_regs_s r;
  rlt_regs_s next_r;
  logic      presc_tick;
  logic      rise;
  logic      fall;
  logic      event_mode;
  logic      gate_mode;
  logic      gate_ok;
  logic      ext_trig;
  logic      wr_cl;
  logic      next_count_enable_bit;
  logic      soft_trig;
  logic      start;
  logic      tick;
  logic      underflow;
  logic      uf_clear;
  logic [7:0] rd_mux;

  // Edge match: bit 0 selects rising, bit 1 falling, both for either edge
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic       r_edge,
                                    input logic       f_edge);
    return (sel[0] & r_edge) | (sel[1] & f_edge);
  endfunction

  // ----------------------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------------------
  rlt_prescaler #(
    .DIV_W (PSC_W)
  ) u_presc (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .sel     (r.count_clock_select),
    .tick    (presc_tick)
  );

  // ----------------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------------
  always_comb begin
    next_r = r;
    // Pin passes two flops; edges are seen only past the second one
    next_r.tin_meta = timer_input_pin;
    next_r.tin_sync = r.tin_meta;
    next_r.tin_prev = r.tin_sync;
    rise = r.tin_sync & ~r.tin_prev;
    fall = ~r.tin_sync & r.tin_prev;

    // Mode decode
    event_mode = r.count_clock_select == `RLT_CSL_EVENT;
    gate_mode  = !event_mode && (r.operating_mode_select[2:1] == 2'b10);
    gate_ok    = r.tin_sync == r.operating_mode_select[0];
    // Edge triggers only exist in internal clock mode; event mode is software-started
    ext_trig   = !event_mode && !r.operating_mode_select[2]
                 && edge_hit(r.operating_mode_select[1:0], rise, fall);

    // Count tick source
    if (event_mode) begin
      tick = edge_hit(r.operating_mode_select[1:0], rise, fall);
    end else begin
      tick = presc_tick && (!gate_mode || gate_ok);
    end

    // Control writes
    wr_cl     = bus.wr && (bus.addr == `RLT_OFS_CTRL_LOWER);
    next_count_enable_bit = wr_cl ? bus.wdata[`RLT_CL_COUNT_ENABLE_BIT] : r.count_enable_bit;
    // Trigger counts only if the same write leaves counting enabled
    soft_trig = wr_cl && bus.wdata[`RLT_CL_TRG] && next_count_enable_bit;
    start     = soft_trig || (r.count_enable_bit && next_count_enable_bit && ext_trig);
    underflow = 1'b0;
    next_r.count_enable_bit = next_count_enable_bit;

    if (bus.wr) begin
      case (bus.addr)
        `RLT_OFS_CTRL_UPPER: begin
          next_r.count_clock_select    = bus.wdata[`RLT_CU_CSL_LSB +: 3];
          next_r.operating_mode_select = bus.wdata[`RLT_CU_MOD_LSB +: 3];
        end
        `RLT_OFS_CTRL_LOWER: begin
          next_r.output_enable_bit    = bus.wdata[`RLT_CL_OUTPUT_ENABLE_BIT];
          next_r.out_level_inv        = bus.wdata[`RLT_CL_OUTL];
          next_r.reload_select_bit    = bus.wdata[`RLT_CL_RELOAD_SELECT_BIT];
          next_r.underflow_irq_enable = bus.wdata[`RLT_CL_UNDERFLOW_IRQ_ENABLE];
        end
        `RLT_OFS_RLD_UPPER: begin
          next_r.reload[15:8] = bus.wdata;
        end
        `RLT_OFS_RLD_LOWER: begin
          next_r.reload[7:0] = bus.wdata;
        end
        `RLT_OFS_INT_MASK: begin
          next_r.underflow_irq_enable = bus.wdata[`RLT_IS_UF];
        end
        default: begin
        end
      endcase
    end

    // Counter state machine
    if (!next_count_enable_bit) begin
      next_r.st = st_stop;
    end else if (start) begin
      next_r.st         = st_run;
      next_r.cnt        = r.reload;
      next_r.tout_level = 1'b0;
    end else begin
      case (r.st)
        st_stop: begin
          next_r.st = st_wait;
        end
        st_wait: begin
          next_r.st = st_wait;
        end
        st_run: begin
          if (tick) begin
            if (r.cnt == `RLT_CNT_ZERO) begin
              underflow = 1'b1;
              if (r.reload_select_bit) begin
                next_r.cnt        = r.reload;
                next_r.tout_level = ~r.tout_level;
              end else begin
                // One-shot: park at all ones until the next trigger
                next_r.cnt = `RLT_CNT_UNDER;
                next_r.st  = st_wait;
              end
            end else begin
              next_r.cnt = r.cnt - 16'h0001;
            end
          end
        end
        default: begin
          next_r.st = st_stop;
        end
      endcase
    end

    // Underflow flag: a set in the clearing cycle wins
    uf_clear = (wr_cl && !bus.wdata[`RLT_CL_UF])
               || (bus.wr && (bus.addr == `RLT_OFS_INT_STAT) && bus.wdata[`RLT_IS_UF]);
    if (underflow) begin
      next_r.underflow_flag = 1'b1;
    end else if (uf_clear) begin
      next_r.underflow_flag = 1'b0;
    end
    next_r.irq = next_r.underflow_flag && next_r.underflow_irq_enable;

    // Output waveform: toggle in reload mode, run indicator in one-shot mode
    if (next_r.reload_select_bit) begin
      next_r.pin_level = next_r.tout_level ^ next_r.out_level_inv;
    end else begin
      next_r.pin_level = (next_r.st == st_run) ^ next_r.out_level_inv;
    end

    // Read mux; data stand for one cycle only
    case (bus.addr)
      `RLT_OFS_CTRL_UPPER: rd_mux = {2'b00, r.operating_mode_select, r.count_clock_select};
      `RLT_OFS_CTRL_LOWER: rd_mux = {r.output_enable_bit, r.out_level_inv,
                                     r.reload_select_bit, r.underflow_irq_enable,
                                     r.underflow_flag, r.count_enable_bit, 1'b0,
                                     r.st == st_run};
      `RLT_OFS_CNT_UPPER:  rd_mux = r.cnt[15:8];
      `RLT_OFS_CNT_LOWER:  rd_mux = r.cnt[7:0];
      `RLT_OFS_RLD_UPPER:  rd_mux = r.reload[15:8];
      `RLT_OFS_RLD_LOWER:  rd_mux = r.reload[7:0];
      `RLT_OFS_INT_STAT:   rd_mux = {7'h00, r.underflow_flag};
      `RLT_OFS_INT_MASK:   rd_mux = {7'h00, r.underflow_irq_enable};
      default:             rd_mux = 8'h00;
    endcase
    next_r.rdata = bus.rd ? rd_mux : 8'h00;
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r <= RST;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from flops
  assign rdata            = r.rdata;
  assign timer_output_pin = r.pin_level;
  assign timer_output_en  = r.output_enable_bit;
  assign irq              = r.irq;

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  sequence s_run_tick_zero;
    r.st == st_run && tick && r.cnt == `RLT_CNT_ZERO && !wr_cl && !start;
  endsequence

  sequence s_soft_start;
    bus.wr && bus.addr == `RLT_OFS_CTRL_LOWER
      && bus.wdata[`RLT_CL_COUNT_ENABLE_BIT] && bus.wdata[`RLT_CL_TRG];
  endsequence

  property p_soft_start;
    s_soft_start |=> r.st == st_run && r.cnt == $past(r.reload);
  endproperty
  a_soft_start: assert property (p_soft_start) else $error("soft start missed");

  property p_stop;
    bus.wr && bus.addr == `RLT_OFS_CTRL_LOWER && !bus.wdata[`RLT_CL_COUNT_ENABLE_BIT]
      |=> r.st == st_stop ##1 (r.st != st_run || $past(start));
  endproperty
  a_stop: assert property (p_stop) else $error("timer did not halt");

  property p_reload;
    s_run_tick_zero ##0 r.reload_select_bit
      |=> r.st == st_run && r.cnt == $past(r.reload) && r.underflow_flag;
  endproperty
  a_reload: assert property (p_reload) else $error("reload on underflow wrong");

  property p_oneshot;
    s_run_tick_zero ##0 !r.reload_select_bit
      |=> r.cnt == `RLT_CNT_UNDER && r.st == st_wait && r.underflow_flag;
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot hold wrong");

  property p_flag_set;
    underflow |=> r.underflow_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_irq;
    irq == (r.underflow_flag && r.underflow_irq_enable);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");

  property p_gate;
    r.st == st_run && gate_mode && !gate_ok && !start && next_count_enable_bit |=> $stable(r.cnt);
  endproperty
  a_gate: assert property (p_gate) else $error("counted outside gate");

  property p_toggle;
    underflow && r.reload_select_bit |=> r.tout_level != $past(r.tout_level);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle on underflow");

  property p_oneshot_out;
    !r.reload_select_bit |-> timer_output_pin == ((r.st == st_run) ^ r.out_level_inv);
  endproperty
  a_oneshot_out: assert property (p_oneshot_out) else $error("run output wrong");

  property p_ext_trig;
    r.count_enable_bit && ext_trig && !wr_cl |=> r.st == st_run && r.cnt == $past(r.reload);
  endproperty
  a_ext_trig: assert property (p_ext_trig) else $error("edge start missed");

  property p_read_live;
    bus.rd && bus.addr == `RLT_OFS_CNT_LOWER |=> rdata == $past(r.cnt[7:0]);
  endproperty
  a_read_live: assert property (p_read_live) else $error("count read wrong");

  // Behavioural check of the line; the level check above mirrors the flop itself
  property p_irq_follow;
    underflow && next_r.underflow_irq_enable |=> irq;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("interrupt not raised");

  property p_clear;
    uf_clear && !underflow |=> !r.underflow_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");

  property p_halted;
    !next_count_enable_bit |=> r.st == st_stop && r.cnt == $past(r.cnt);
  endproperty
  a_halted: assert property (p_halted) else $error("counter moved while halted");

  property p_event_tick;
    event_mode && r.st == st_run && tick && r.cnt != `RLT_CNT_ZERO && !start && next_count_enable_bit
      |=> r.cnt == $past(r.cnt) - 16'h0001;
  endproperty
  a_event_tick: assert property (p_event_tick) else $error("event edge not counted");

endmodule

`default_nettype wire

// ---- verification/rlt_input_src.sv ----
// Model of the trigger, gate and event source that feeds the timer input pin
`timescale 1ns/1ns
`default_nettype none

module rlt_input_src (
  input  wire logic clk_sys,
  output var logic  level
);
  // ----------------------------------------------------------------------------
  // Level driver
  // ----------------------------------------------------------------------------
  // Idle low until a scenario asks for another level
  initial level = 1'b0;

  // Change just after an edge, then hold for n clocks; a long n models a slow source
  task automatic hold(input logic v, input int n);
    @(posedge clk_sys);
    level <= v;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
endmodule

`default_nettype wire

// ---- verification/rlt_timer_tb_top.sv ----
// Self-checking bench for the reload down-counter timer channel
`timescale 1ns/1ns
`default_nettype none
`include "rlt_defines.svh"

module rlt_timer_tb_top
  import rlt_pkg::*;
;
  logic       clk_sys;
  logic       nrst;
  rlt_bus_s   bus;
  logic [7:0] rdata;
  logic       timer_input_pin;
  logic       timer_output_pin;
  logic       timer_output_en;
  logic       irq;
  int         errors;
  int         comparisons;
  int         n;

  // ----------------------------------------------------------------------------
  // Clock, partner and design
  // ----------------------------------------------------------------------------
  initial clk_sys = 1'b0;
  always #20 clk_sys = ~clk_sys;

  rlt_input_src src (
    .clk_sys (clk_sys),
    .level   (timer_input_pin)
  );

  rlt_timer #(.PSC_W(7)) uut (
    .clk_sys          (clk_sys),
    .nrst             (nrst),
    .bus              (bus),
    .rdata            (rdata),
    .timer_input_pin  (timer_input_pin),
    .timer_output_pin (timer_output_pin),
    .timer_output_en  (timer_output_en),
    .irq              (irq)
  );

  // ----------------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------------
  task automatic report_and_stop();
    if (errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  // One-cycle write strobe; an edge always passes before the next request
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus <= '0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus <= '0;
    #1;
    chk8(rdata, e);
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  // Bounded wait for the interrupt line; cnt returns the clocks spent
  task automatic wait_irq(input int lim, output int cnt);
    cnt = 0;
    while (irq !== 1'b1 && cnt < lim) begin
      idle(1);
      cnt++;
    end
    chk1(irq, 1'b1);
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset();
    chk1(irq, 1'b0);
    chk1(timer_output_en, 1'b0);
    rd_chk(`RLT_OFS_CTRL_LOWER, 8'h00);
    wr(`RLT_OFS_CNT_LOWER, 8'h5A);
    rd_chk(`RLT_OFS_CNT_LOWER, 8'h00);
    wr(`RLT_OFS_RLD_UPPER, 8'hA5);
    rd_chk(`RLT_OFS_RLD_UPPER, 8'hA5);
  endtask

  // Periodic mode: toggle per underflow, flag, mask, then halt
  task automatic t_reload();
    wr(`RLT_OFS_RLD_UPPER, 8'h01);
    wr(`RLT_OFS_RLD_LOWER, 8'h05);
    wr(`RLT_OFS_CTRL_UPPER, 8'h00);
    wr(`RLT_OFS_CTRL_LOWER, 8'hB6);
    chk1(timer_output_en, 1'b1);
    chk1(timer_output_pin, 1'b0);
    rd_chk(`RLT_OFS_CNT_UPPER, 8'h01);
    wait_irq(700, n);
    chk1(timer_output_pin, 1'b1);
    rd_chk(`RLT_OFS_CNT_UPPER, 8'h01);
    rd_chk(`RLT_OFS_CTRL_LOWER, 8'hBD);
    wr(`RLT_OFS_CTRL_LOWER, 8'hB4);
    chk1(irq, 1'b0);
    wait_irq(700, n);
    chk1(timer_output_pin, 1'b0);
    wr(`RLT_OFS_INT_MASK, 8'h00);
    chk1(irq, 1'b0);
    rd_chk(`RLT_OFS_INT_STAT, 8'h01);
    wr(`RLT_OFS_INT_MASK, 8'h01);
    chk1(irq, 1'b1);
    wr(`RLT_OFS_INT_STAT, 8'h01);
    chk1(irq, 1'b0);
    wr(`RLT_OFS_CTRL_LOWER, 8'h00);
    chk1(timer_output_en, 1'b0);
    wr(`RLT_OFS_CTRL_LOWER, 8'h12);
    idle(700);
    chk1(irq, 1'b0);
    rd_chk(`RLT_OFS_CTRL_LOWER, 8'h10);
  endtask

  // One-shot at three prescaler rates; timing shows the selected divider
  task automatic t_oneshot();
    int div;
    wr(`RLT_OFS_RLD_UPPER, 8'h00);
    wr(`RLT_OFS_RLD_LOWER, 8'h03);
    for (int s = 0; s < 3; s++) begin
      div = 2 << s;
      wr(`RLT_OFS_CTRL_UPPER, 8'(s));
      wr(`RLT_OFS_CTRL_LOWER, 8'h96);
      chk1(timer_output_pin, 1'b1);
      wait_irq(100, n);
      chk1(n >= 3 * div && n <= 4 * div + 4, 1'b1);
      chk1(timer_output_pin, 1'b0);
      idle(20);
      rd_chk(`RLT_OFS_CNT_UPPER, 8'hFF);
      rd_chk(`RLT_OFS_CNT_LOWER, 8'hFF);
    end
  endtask

  // Edge starts: the wrong edge is ignored, the chosen one starts the count
  task automatic t_trigger();
    wr(`RLT_OFS_RLD_UPPER, 8'h01);
    for (int m = 1; m < 4; m++) begin
      wr(`RLT_OFS_CTRL_LOWER, 8'h00);
      src.hold(m == 1, 4);
      wr(`RLT_OFS_CTRL_UPPER, 8'(m << 3));
      wr(`RLT_OFS_CTRL_LOWER, 8'h84);
      src.hold(m != 1, 8);
      chk1(timer_output_pin, m == 3);
      src.hold(m == 1, 8);
      chk1(timer_output_pin, 1'b1);
    end
    wr(`RLT_OFS_CTRL_LOWER, 8'h80);
    src.hold(1'b1, 8);
    chk1(timer_output_pin, 1'b0);
    rd_chk(`RLT_OFS_CTRL_LOWER, 8'h80);
    wr(`RLT_OFS_CTRL_LOWER, 8'hC0);
    chk1(timer_output_pin, 1'b1);
  endtask

  // Gate low then gate high: counter frozen at the blocking level only
  task automatic t_gate();
    for (int g = 0; g < 2; g++) begin
      src.hold(g == 0, 4);
      wr(`RLT_OFS_CTRL_UPPER, 8'(8'h20 | (g << 3)));
      wr(`RLT_OFS_CTRL_LOWER, 8'h86);
      idle(40);
      rd_chk(`RLT_OFS_CNT_LOWER, 8'h03);
      src.hold(g == 1, 40);
      rd_chk(`RLT_OFS_CNT_UPPER, 8'h00);
    end
  endtask

  // Event count on rising edges, then on falling edges only; the prescaler must not count
  task automatic t_event();
    wr(`RLT_OFS_RLD_LOWER, 8'h02);
    wr(`RLT_OFS_RLD_UPPER, 8'h00);
    src.hold(1'b0, 4);
    wr(`RLT_OFS_CTRL_UPPER, 8'h0F);
    wr(`RLT_OFS_CTRL_LOWER, 8'h96);
    idle(40);
    rd_chk(`RLT_OFS_CNT_LOWER, 8'h02);
    rd_chk(`RLT_OFS_CTRL_UPPER, 8'h0F);
    rd_chk(`RLT_OFS_RLD_LOWER, 8'h02);
    for (int k = 0; k < 2; k++) begin
      src.hold(1'b1, 6);
      src.hold(1'b0, 6);
    end
    rd_chk(`RLT_OFS_CNT_LOWER, 8'h00);
    chk1(irq, 1'b0);
    src.hold(1'b1, 6);
    chk1(irq, 1'b1);
    // Falling edges only: the rising edge after it must not count
    wr(`RLT_OFS_CTRL_UPPER, 8'h17);
    wr(`RLT_OFS_CTRL_LOWER, 8'h96);
    chk1(irq, 1'b0);
    src.hold(1'b0, 6);
    src.hold(1'b1, 6);
    rd_chk(`RLT_OFS_CNT_LOWER, 8'h01);
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------------
  initial begin
    errors = 0;
    comparisons = 0;
    nrst = 1'b0;
    bus = '0;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_reload();
    t_oneshot();
    t_trigger();
    t_gate();
    t_event();
    report_and_stop();
  end

  // The whole run needs a few thousand clocks; this span leaves ample margin
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    report_and_stop();
  end
endmodule

`default_nettype wire
